/* File: src/adt_threshold.v */
// Async-list done interrupt: done-count threshold and NAK time-out.
// Assumes command strobe precedes data strobes; ms_tick is a 1-cycle pulse.
`timescale 1ns/1ps
`include "adt_defs.vh"
module adt_threshold #(
    parameter CNT_W = `ADT_CNT_W,
    parameter TO_W = `ADT_TO_W
) (
    input wire clk,
    input wire rst,
    input wire cmd_valid,
    input wire [7:0] cmd_code,
    input wire data_wr,
    input wire [15:0] data_in,
    input wire data_rd,
    input wire desc_done,
    input wire desc_ack,
    input wire nak_retry,
    input wire ms_tick,
    output reg [15:0] data_out,
    output reg async_list_irq
);
    localparam CMD_W = `ADT_CMD_W;
    localparam DATA_W = `ADT_DATA_W;
    localparam CNT_PAD = DATA_W - CNT_W;
    localparam TO_PAD = DATA_W - TO_W;

    reg [CMD_W-1:0] cmd_r;
    reg [CNT_W-1:0] cnt_thr_r;
    reg [TO_W-1:0] to_val_r;
    reg [CNT_W-1:0] done_cnt_r;
    reg [CNT_W-1:0] done_cnt_nxt;
    reg [TO_W-1:0] ms_cnt_r;
    reg [TO_W-1:0] ms_cnt_nxt;
    reg [DATA_W-1:0] rd_word;
    reg cnt_hit;
    reg to_hit;
    wire done_ev;
    wire wr_cnt_sel;
    wire wr_to_sel;
    wire to_enable;
    wire timer_run;

    // Done-count step, cut back to the field width
    function [CNT_W-1:0] cnt_inc;
        input [CNT_W-1:0] val;
        reg [CNT_W:0] sum;
        begin
            sum = {1'b0, val} + {{CNT_W{1'b0}}, 1'b1};
            cnt_inc = sum[CNT_W-1:0];
        end
    endfunction

    // One extra bit so the compare cannot wrap
    function cnt_reached;
        input [CNT_W-1:0] val;
        input [CNT_W-1:0] thr;
        reg [CNT_W:0] sum;
        begin
            sum = {1'b0, val} + {{CNT_W{1'b0}}, 1'b1};
            cnt_reached = (sum >= {1'b0, thr});
        end
    endfunction

    function [TO_W-1:0] to_inc;
        input [TO_W-1:0] val;
        reg [TO_W:0] sum;
        begin
            sum = {1'b0, val} + {{TO_W{1'b0}}, 1'b1};
            to_inc = sum[TO_W-1:0];
        end
    endfunction

    function to_reached;
        input [TO_W-1:0] val;
        input [TO_W-1:0] lim;
        reg [TO_W:0] sum;
        begin
            sum = {1'b0, val} + {{TO_W{1'b0}}, 1'b1};
            to_reached = (sum >= {1'b0, lim});
        end
    endfunction

    assign done_ev = desc_done & desc_ack;
    assign wr_cnt_sel = data_wr && (cmd_r == `ADT_CMD_WR_CNT);
    assign wr_to_sel = data_wr && (cmd_r == `ADT_CMD_WR_TO);
    assign to_enable = (to_val_r != {TO_W{1'b0}});
    // Progress on the list restarts the retry clock
    assign timer_run = to_enable && nak_retry && !done_ev;

    // Command stays latched until the next command strobe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_r <= `ADT_CMD_RST;
        end else begin
            if (cmd_valid) begin
                cmd_r <= cmd_code;
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_thr_r <= `ADT_CNT_RST;
        end else begin
            if (wr_cnt_sel) begin
                // Zero is forbidden to software; it acts like one
                cnt_thr_r <= data_in[CNT_W-1:0];
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            to_val_r <= `ADT_TO_RST;
        end else begin
            if (wr_to_sel) begin
                to_val_r <= data_in[TO_W-1:0];
            end
        end
    end

    always @* begin
        cnt_hit = 1'b0;
        done_cnt_nxt = done_cnt_r;
        if (done_ev) begin
            if (cnt_reached(done_cnt_r, cnt_thr_r)) begin
                cnt_hit = 1'b1;
                done_cnt_nxt = {CNT_W{1'b0}};
            end else begin
                done_cnt_nxt = cnt_inc(done_cnt_r);
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            done_cnt_r <= {CNT_W{1'b0}};
        end else begin
            done_cnt_r <= done_cnt_nxt;
        end
    end

    // Counter holds one below its limit, so each later tick fires again
    always @* begin
        to_hit = 1'b0;
        ms_cnt_nxt = {TO_W{1'b0}};
        if (timer_run) begin
            ms_cnt_nxt = ms_cnt_r;
            if (ms_tick) begin
                if (to_reached(ms_cnt_r, to_val_r)) begin
                    to_hit = 1'b1;
                end else begin
                    ms_cnt_nxt = to_inc(ms_cnt_r);
                end
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ms_cnt_r <= {TO_W{1'b0}};
        end else begin
            ms_cnt_r <= ms_cnt_nxt;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            async_list_irq <= 1'b0;
        end else begin
            async_list_irq <= cnt_hit | to_hit;
        end
    end

    // Reserved bits always read back as zero
    always @* begin
        case (cmd_r)
            `ADT_CMD_RD_CNT: begin
                rd_word = {{CNT_PAD{1'b0}}, cnt_thr_r};
            end
            `ADT_CMD_RD_TO: begin
                rd_word = {{TO_PAD{1'b0}}, to_val_r};
            end
            default: begin
                rd_word = `ADT_DATA_RST;
            end
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            data_out <= `ADT_DATA_RST;
        end else begin
            if (data_rd) begin
                data_out <= rd_word;
            end
        end
    end
endmodule

/* File: include/adt_defs.vh */
// Constants for the async-list done interrupt threshold block.
// Assumes a command/data register port as on the microprocessor bus.
// How it works
// - Count completed async-list descriptors; interrupt when count reaches threshold.
// - Threshold 8 gives one interrupt per eight completed descriptors.
// - Threshold read with command 51h, written with command D1h.
// - Threshold is five bits 4..0, reset one; bits 15..5 reserved.
// - A time-out condition can also raise the async-list interrupt.
// - Time-out value is maximum NAK retry time in milliseconds.
// - Count and time-out sources work together; either raises interrupt.
// - Time-out read with command 52h, written with command D2h.
// - Time-out is eight bits 7..0; bits 15..8 reserved.
// - Descriptor counts done only when processed and ACK received.
`ifndef ADT_DEFS_VH
`define ADT_DEFS_VH
`define ADT_CMD_RD_CNT 8'h51
`define ADT_CMD_WR_CNT 8'hD1
`define ADT_CMD_RD_TO 8'h52
`define ADT_CMD_WR_TO 8'hD2
`define ADT_CNT_W 5
`define ADT_TO_W 8
`define ADT_CNT_RST 5'h01
`define ADT_TO_RST 8'h00
`define ADT_CMD_W 8
`define ADT_DATA_W 16
`define ADT_CMD_RST 8'h00
`define ADT_DATA_RST 16'h0000
`endif

/* File: tb/adt_chk_assertions.sv */
// Port checker for adt_threshold: interrupt causes and read data.
// Single clock, asynchronous active-high reset.
`timescale 1ns/1ps
module adt_chk (
    input wire clk,
    input wire rst,
    input wire data_rd,
    input wire desc_done,
    input wire desc_ack,
    input wire nak_retry,
    input wire ms_tick,
    input wire async_list_irq,
    input wire [15:0] data_out
);
wire q = async_list_irq, d = desc_done, t = ms_tick, r = data_rd;
wire [15:0] o = data_out;
default clocking @(posedge clk); endclocking
default disable iff (rst);
AST_RSV: assert property (r |=> !o[15:8]) else $error("rsv");
AST_HLD: assert property (!r |=> $stable(o)) else $error("hold");
AST_ACK: assert property (d && !desc_ack && !t |=> !q) else $error("ack");
AST_SRC: assert property (q |-> $past(d && desc_ack || t)) else $error("src");
AST_IDL: assert property (!d && !t |=> !q) else $error("idle");
AST_NAK: assert property (!nak_retry && !d |=> !q) else $error("nak");
AST_TOK: assert property (q && !$past(d) |-> $past(nak_retry)) else $error("tok");
AST_RST: assert property ($fell(rst) |-> o == 0 && !q) else $error("rst");
endmodule
bind adt_threshold adt_chk adt_chk_inst (.*);

/* File: tb/tb.sv */
// Bench for adt_threshold: register access and interrupts.
// Inputs change on falling clock edges.
`timescale 1ns/1ps
module tb;
reg clk = 1'b0;
reg rst = 1'b1;
reg cmd_valid = 1'b0;
reg data_wr = 1'b0;
reg data_rd = 1'b0;
reg desc_done = 1'b0;
reg desc_ack = 1'b0;
reg nak_retry = 1'b0;
reg ms_tick = 1'b0;
reg [7:0] cmd_code = 8'h00;
reg [15:0] data_in = 16'h0000;
wire [15:0] data_out;
wire async_list_irq;
integer error_cnt = 0;
integer n_checks = 0;
integer irq_seen = 0;
integer cyc = 0;

adt_threshold adt_threshold_inst (
    .clk(clk),
    .rst(rst),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .data_wr(data_wr),
    .data_in(data_in),
    .data_rd(data_rd),
    .desc_done(desc_done),
    .desc_ack(desc_ack),
    .nak_retry(nak_retry),
    .ms_tick(ms_tick),
    .data_out(data_out),
    .async_list_irq(async_list_irq)
);

always #20 clk = ~clk;

// Tests need about 100 cycles; ceiling leaves wide margin
always @(posedge clk) begin
    if (async_list_irq === 1'b1) begin
        irq_seen = irq_seen + 1;
    end
    cyc = cyc + 1;
    if (cyc == 2000) begin
        error_cnt = error_cnt + 1;
        give_verdict;
    end
end

task chk_reg(input [15:0] got, input [15:0] exp);
begin
    n_checks = n_checks + 1;
    if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
end
endtask

task chk_irq(input [31:0] exp);
begin
    n_checks = n_checks + 1;
    if (irq_seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time,
            irq_seen, exp);
    end
end
endtask

task send_cmd(input [7:0] code);
begin
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    @(negedge clk);
    cmd_valid = 1'b0;
end
endtask

task write_reg(input [7:0] code, input [15:0] val);
begin
    send_cmd(code);
    data_wr = 1'b1;
    data_in = val;
    @(negedge clk);
    data_wr = 1'b0;
end
endtask

task read_reg(input [7:0] code, input [15:0] exp);
begin
    send_cmd(code);
    data_rd = 1'b1;
    @(negedge clk);
    data_rd = 1'b0;
    @(negedge clk);
    chk_reg(data_out, exp);
end
endtask

task pulse(input d, input a, input t);
begin
    @(negedge clk);
    desc_done = d;
    desc_ack = a;
    ms_tick = t;
    @(negedge clk);
    desc_done = 1'b0;
    desc_ack = 1'b0;
    ms_tick = 1'b0;
end
endtask

task give_verdict;
begin
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
end
endtask

initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    read_reg(8'h51, 16'h0001);
    read_reg(8'h52, 16'h0000);
    write_reg(8'hD1, 16'hFFFF);
    read_reg(8'h51, 16'h001F);
    read_reg(8'hD1, 16'h0000);
    write_reg(8'hD1, 16'h0008);
    repeat (3) pulse(1'b1, 1'b1, 1'b0);
    pulse(1'b1, 1'b0, 1'b0);
    repeat (12) pulse(1'b1, 1'b1, 1'b0);
    @(negedge clk) chk_irq(1);
    pulse(1'b1, 1'b1, 1'b0);
    @(negedge clk) chk_irq(2);
    write_reg(8'hD2, 16'hFF03);
    read_reg(8'h52, 16'h0003);
    nak_retry = 1'b1;
    repeat (4) pulse(1'b0, 1'b0, 1'b1);
    @(negedge clk) chk_irq(4);
    write_reg(8'hD2, 16'h0000);
    repeat (4) pulse(1'b0, 1'b0, 1'b1);
    @(negedge clk) chk_irq(4);
    nak_retry = 1'b0;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    read_reg(8'h51, 16'h0001);
    read_reg(8'h52, 16'h0000);
    give_verdict;
end
endmodule
